/* verilog/config_port_access_logic.v */
`timescale 1ns/100ps
`default_nettype none
`include "cfg_port_consts.vh"

// Summary of operation
// - Key and index at strap base, data +1
// - Ignore all port cycles while AEN high
// - Index/data ports only in Configuration state
// - Key 0x55 enters Configuration state
// - Key 0xAA returns to Run state
// - Only Run and Configuration; Run accepts entry
// - Hard reset loads defaults, starts in Run
// - Select bit 7 enables open mode
// - Select bits 1:0 choose open pair address
// - Open data reaches device seven 0x82-0x9A
// - Out-of-range open index blocks data access
// - Control bit 0 write causes soft reset
module config_port_access_logic (
	// Clock and reset
	input wire sys_clk,
	input wire rstn,
	// Strap
	input wire mode_strap,
	// Host I/O cycle
	input wire [15:0] io_addr,
	input wire aen,
	input wire io_wr,
	input wire io_rd,
	input wire [7:0] io_wdata,
	output reg [7:0] io_rdata,
	output reg io_rdata_valid,
	// Status
	output reg config_state,
	output reg [7:0] open_access_select
);
	// ----------------------------------------
	// State encoding
	// ----------------------------------------
	localparam RUN = 1'b0;
	localparam CONFIG = 1'b1;

	reg strap;
	reg [7:0] cfg_index;
	reg [7:0] open_index;
	reg [7:0] device_number;
	reg soft_pulse;
	reg next_state;
	reg [15:0] cfg_base;
	reg [15:0] open_base;
	wire hit_cfg_index;
	wire hit_cfg_data;
	wire hit_open_index;
	wire hit_open_data;
	wire open_in_range;
	wire cfg_dev7_reg;
	wire [7:0] open_off;
	wire [7:0] cfg_off;
	wire bank_wr;
	wire [4:0] bank_wr_sel;
	wire [4:0] bank_rd_sel;
	wire [7:0] bank_rd;
	reg [7:0] cfg_read;

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	always @* begin
		cfg_base = strap ? `CFG_BASE_STRAP_HI : `CFG_BASE_STRAP_LO;
		case (open_access_select[1:0])
			2'b00: open_base = `OPEN_PAIR0_INDEX;
			2'b01: open_base = `OPEN_PAIR1_INDEX;
			2'b10: open_base = `OPEN_PAIR2_INDEX;
			default: open_base = `OPEN_PAIR3_INDEX;
		endcase
	end

	// The key port shares the index address; in Configuration state a
	// write there is both an index load and a key check.
	assign hit_cfg_index = !aen && io_addr == cfg_base;
	assign hit_cfg_data = !aen && io_addr == cfg_base + 16'h0001;
	// Open pair decodes only in Run state with the enable set.
	assign hit_open_index = !aen && config_state == RUN &&
		open_access_select[`OPEN_ENABLE_BIT] && io_addr == open_base;
	assign hit_open_data = !aen && config_state == RUN &&
		open_access_select[`OPEN_ENABLE_BIT] &&
		io_addr == open_base + 16'h0001;

	assign open_in_range = open_index >= `OPEN_INDEX_FIRST &&
		open_index <= `OPEN_INDEX_LAST;
	assign cfg_dev7_reg = device_number == `OPEN_DEVICE &&
		cfg_index >= `OPEN_INDEX_FIRST && cfg_index <= `OPEN_INDEX_LAST;
	assign open_off = open_index - `OPEN_INDEX_FIRST;
	assign cfg_off = cfg_index - `OPEN_INDEX_FIRST;

	// Bank writes come from the config data port or an in-range open
	// data write; the two never overlap since they need opposite states.
	assign bank_wr = io_wr && ((hit_cfg_data && config_state == CONFIG &&
		cfg_dev7_reg) || (hit_open_data && open_in_range));
	assign bank_wr_sel = (config_state == CONFIG) ? cfg_off[4:0] :
		open_off[4:0];
	assign bank_rd_sel = bank_wr_sel;

	open_reg_bank #(
		.COUNT(`OPEN_REG_COUNT)
	) u_bank (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.soft_clear(soft_pulse),
		.wr_en(bank_wr),
		.wr_sel(bank_wr_sel),
		.wr_data(io_wdata),
		.rd_sel(bank_rd_sel),
		.rd_data(bank_rd)
	);

	// ----------------------------------------
	// Key state machine
	// ----------------------------------------
	always @* begin
		next_state = config_state;
		if (io_wr && hit_cfg_index) begin
			case (config_state)
				RUN: begin
					if (io_wdata == `KEY_ENTER) begin
						next_state = CONFIG;
					end
				end
				CONFIG: begin
					if (io_wdata == `KEY_EXIT) begin
						next_state = RUN;
					end
				end
				default: next_state = RUN;
			endcase
		end
		// Any other key value falls through unchanged.
	end

	// Configuration read mux for the global registers and the bank.
	always @* begin
		cfg_read = 8'h00;
		if (cfg_dev7_reg) begin
			cfg_read = bank_rd;
		end else begin
			case (cfg_index)
				`IDX_OPEN_ACCESS_SELECT: cfg_read = open_access_select;
				`IDX_DEVICE_NUMBER: cfg_read = device_number;
				`IDX_DEVICE_ID: cfg_read = `DEVICE_ID_VALUE;
				default: cfg_read = 8'h00;
			endcase
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always @(posedge sys_clk) begin
		if (!rstn) begin
			config_state <= RUN;
			cfg_index <= 8'h00;
			open_index <= 8'h00;
			device_number <= 8'h00;
			soft_pulse <= 1'b0;
			io_rdata <= 8'h00;
			io_rdata_valid <= 1'b0;
			open_access_select <= `OPEN_ACCESS_RESET_LO;
		end else begin
			config_state <= next_state;
			soft_pulse <= 1'b0;
			io_rdata_valid <= 1'b0;
			io_rdata <= 8'h00;
			// Configuration index loads happen only in Configuration state.
			if (io_wr && hit_cfg_index && config_state == CONFIG) begin
				cfg_index <= io_wdata;
			end
			if (io_wr && hit_open_index) begin
				open_index <= io_wdata;
			end
			if (io_wr && hit_cfg_data && config_state == CONFIG) begin
				case (cfg_index)
					`IDX_CONFIG_CONTROL: begin
						soft_pulse <= io_wdata[`SOFT_RESET_BIT];
					end
					`IDX_OPEN_ACCESS_SELECT: open_access_select <= io_wdata;
					`IDX_DEVICE_NUMBER: device_number <= io_wdata;
					default: ;
				endcase
			end
			if (soft_pulse) begin
				device_number <= 8'h00;
			end
			if (io_rd && config_state == CONFIG && hit_cfg_index) begin
				io_rdata <= cfg_index;
				io_rdata_valid <= 1'b1;
			end else if (io_rd && config_state == CONFIG && hit_cfg_data) begin
				io_rdata <= cfg_read;
				io_rdata_valid <= 1'b1;
			end else if (io_rd && hit_open_index) begin
				io_rdata <= open_index;
				io_rdata_valid <= 1'b1;
			end else if (io_rd && hit_open_data && open_in_range) begin
				io_rdata <= bank_rd;
				io_rdata_valid <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Strap sampling
	// ----------------------------------------
	// The strap flop follows the pin through reset as well, so the base
	// decode already matches the pin at the first edge after release; a
	// reset value here would decode the wrong base for one cycle.
	always @(posedge sys_clk) begin
		strap <= mode_strap;
	end
endmodule
`default_nettype wire

/* verilog/cfg_port_consts.vh */
`ifndef CFG_PORT_CONSTS_VH
`define CFG_PORT_CONSTS_VH

// ----------------------------------------
// Host port addresses
// ----------------------------------------
`define CFG_BASE_STRAP_LO 16'h03f0
`define CFG_BASE_STRAP_HI 16'h0370
`define OPEN_PAIR0_INDEX 16'h00e0
`define OPEN_PAIR1_INDEX 16'h00e2
`define OPEN_PAIR2_INDEX 16'h00e4
`define OPEN_PAIR3_INDEX 16'h00ea

// ----------------------------------------
// Keys
// ----------------------------------------
`define KEY_ENTER 8'h55
`define KEY_EXIT 8'haa

// ----------------------------------------
// Global register indices and fields
// ----------------------------------------
`define IDX_CONFIG_CONTROL 8'h02
`define IDX_OPEN_ACCESS_SELECT 8'h03
`define IDX_DEVICE_NUMBER 8'h07
`define IDX_DEVICE_ID 8'h20
`define SOFT_RESET_BIT 0
`define OPEN_ENABLE_BIT 7
`define OPEN_ACCESS_RESET_LO 8'h01
`define OPEN_ACCESS_RESET_HI 8'h02
`define DEVICE_ID_VALUE 8'h5a

// ----------------------------------------
// Open-mode window into logical device seven
// ----------------------------------------
`define OPEN_DEVICE 8'h07
`define OPEN_INDEX_FIRST 8'h82
`define OPEN_INDEX_LAST 8'h9a
`define OPEN_REG_COUNT 25
`define OPEN_REG_RESET 8'h00

`endif

/* verilog/open_reg_bank.v */
`timescale 1ns/100ps
`default_nettype none
`include "cfg_port_consts.vh"

// Flip-flop bank for the logical device seven registers that are
// reachable both through the configuration ports and in open mode.
module open_reg_bank #(
	parameter COUNT = `OPEN_REG_COUNT
) (
	// Clock and reset
	input wire sys_clk,
	input wire rstn,
	input wire soft_clear,
	// Access
	input wire wr_en,
	input wire [4:0] wr_sel,
	input wire [7:0] wr_data,
	input wire [4:0] rd_sel,
	output wire [7:0] rd_data
);
	reg [7:0] mem [0:COUNT-1];
	genvar i;

	generate
		for (i = 0; i < COUNT; i = i + 1) begin : g_reg
			always @(posedge sys_clk) begin
				if (!rstn || soft_clear) begin
					mem[i] <= `OPEN_REG_RESET;
				end else if (wr_en && wr_sel == i) begin
					mem[i] <= wr_data;
				end
			end
		end
	endgenerate

	assign rd_data = (rd_sel < COUNT) ? mem[rd_sel] : 8'h00;
endmodule
`default_nettype wire

/* tb/cfg_host.sv */
`timescale 1ns/100ps
`default_nettype none
module cfg_host (
	// Host cycle
	input wire logic sys_clk,
	output logic [15:0] io_addr,
	output logic aen,
	output logic io_wr,
	output logic io_rd,
	output logic [7:0] io_wdata,
	input wire logic [7:0] io_rdata,
	input wire logic io_rdata_valid
);
	initial {io_addr, io_wdata, aen, io_wr, io_rd} = '0;
	// Released address and data show the inverse and the strobes drop low, so stale values never decode.
	task automatic xfer(input w, input [15:0] a, input [7:0] d, input e,
		output [7:0] q, output v);
		@(negedge sys_clk);
		{io_addr, io_wdata, aen, io_wr, io_rd} = {a, d, e, w, !w};
		@(negedge sys_clk);
		q = io_rdata;
		v = io_rdata_valid;
		{io_addr, io_wdata, aen, io_wr, io_rd} = {~a, ~d, 3'b000};
	endtask
endmodule
`default_nettype wire

/* tb/cfg_chk_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
`include "cfg_port_consts.vh"
module cfg_chk (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// Host side
	input wire logic mode_strap,
	input wire logic [15:0] io_addr,
	input wire logic aen,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [7:0] io_wdata,
	input wire logic [7:0] io_rdata,
	input wire logic io_rdata_valid,
	// Status
	input wire logic config_state,
	input wire logic [7:0] open_access_select
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	// The decode sees the strap one clock late, so this does too.
	logic strap_q = 1'b0;
	always @(posedge sys_clk) strap_q <= mode_strap;
	wire [15:0] base = strap_q ? `CFG_BASE_STRAP_HI : `CFG_BASE_STRAP_LO;
	wire kw = io_wr && !aen && io_addr == base;
	wire rq = io_rd && !aen;
	wire en = io_wdata == `KEY_ENTER;
	wire ex = io_wdata == `KEY_EXIT;
	AST_ENTER:
		assert property (kw && en |=> config_state) else $error("no entry");
	AST_EXIT:
		assert property (kw && ex |=> !config_state) else $error("no exit");
	AST_HOLD:
		assert property (!(kw && (en || ex)) |=> $stable(config_state))
		else $error("state moved");
	AST_AEN:
		assert property (aen |=> !io_rdata_valid) else $error("aen answered");
	AST_RUN:
		assert property (!config_state && rq && io_addr[15:1] == base[15:1]
			|=> !io_rdata_valid) else $error("run decode");
	AST_IDX:
		assert property (config_state && rq && io_addr == base
			|=> io_rdata_valid) else $error("index unanswered");
	AST_CAUSE:
		assert property (io_rdata_valid |-> $past(io_rd) && !$past(aen))
		else $error("answer without read");
	AST_SEL:
		assert property ($past(rstn) && $changed(open_access_select)
			|-> $past(config_state)) else $error("select set in run");
	COV_ENTER: cover property (kw && en && !config_state);
	COV_OPEN: cover property (io_rdata_valid && !config_state);
	COV_EXIT: cover property ($fell(config_state));
endmodule
bind config_port_access_logic cfg_chk u_chk (.sys_clk(sys_clk), .rstn(rstn),
	.mode_strap(mode_strap), .io_addr(io_addr), .aen(aen), .io_wr(io_wr),
	.io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
	.io_rdata_valid(io_rdata_valid), .config_state(config_state),
	.open_access_select(open_access_select));
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/100ps
`default_nettype none
`include "cfg_port_consts.vh"
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin num_errors++; \
	$display("BAD %s exp %h got %h", n, e, s); end end
module tb;
	logic sys_clk = 0, rstn = 0, mode_strap = 0, v;
	wire [15:0] io_addr;
	wire aen, io_wr, io_rd, io_rdata_valid, config_state;
	wire [7:0] io_wdata, io_rdata, open_access_select;
	int num_errors = 0, checked = 0, cyc = 0, k, r;
	int seed = 32'hdda874b7;
	logic [7:0] q, d, sel, bad;
	logic [7:0] bank [0:24];
	logic [15:0] base, dp, op, od;
	logic [15:0] pairs [4] = '{`OPEN_PAIR0_INDEX, `OPEN_PAIR1_INDEX,
		`OPEN_PAIR2_INDEX, `OPEN_PAIR3_INDEX};
	always #25 sys_clk = ~sys_clk;
	config_port_access_logic u_dut (.sys_clk(sys_clk), .rstn(rstn),
		.mode_strap(mode_strap), .io_addr(io_addr), .aen(aen),
		.io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
		.io_rdata(io_rdata), .io_rdata_valid(io_rdata_valid),
		.config_state(config_state), .open_access_select(open_access_select));
	cfg_host u_host (.sys_clk(sys_clk), .io_addr(io_addr), .aen(aen),
		.io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
		.io_rdata(io_rdata), .io_rdata_valid(io_rdata_valid));
	task automatic wr(input [15:0] a, input [7:0] x, input e = 0);
		u_host.xfer(1, a, x, e, q, v);
	endtask
	task automatic rd(input [15:0] a, input ev, input [7:0] ex);
		u_host.xfer(0, a, 8'h00, 0, q, v);
		`CHK("valid", ev, v)
		`CHK("rdata", ev ? ex : 8'h00, q)
	endtask
	task automatic cfg(input [7:0] i, input [7:0] x);
		wr(base, i);
		wr(dp, x);
	endtask
	task automatic give_verdict;
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 3000) begin
			num_errors++;
			give_verdict;
		end
	end
	initial begin
		repeat (3) @(negedge sys_clk);
		rstn = 1;
		@(negedge sys_clk);
		`CHK("state", 1'b0, config_state)
		`CHK("sel", `OPEN_ACCESS_RESET_LO, open_access_select)
		for (int p = 0; p < 4; p++) begin
			mode_strap = p[0];
			base = p[0] ? `CFG_BASE_STRAP_HI : `CFG_BASE_STRAP_LO;
			dp = base + 16'h0001;
			op = pairs[p];
			od = op + 16'h0001;
			rd(base, 0, 0);
			wr(base, `KEY_ENTER, 1);
			r = $random(seed);
			wr(base, r[7:0] & 8'hf0 | 8'h01);
			`CHK("state", 1'b0, config_state)
			wr(base, `KEY_ENTER);
			`CHK("state", 1'b1, config_state)
			sel = 8'h80 | p[1:0];
			cfg(`IDX_OPEN_ACCESS_SELECT, sel);
			`CHK("sel", sel, open_access_select)
			cfg(`IDX_DEVICE_NUMBER, `OPEN_DEVICE);
			k = p == 0 ? 0 : p == 3 ? 24 : {$random(seed)} % 25;
			r = $random(seed);
			d = r[7:0];
			bank[k] = d;
			cfg(`OPEN_INDEX_FIRST + k[7:0], d);
			rd(dp, 1, bank[k]);
			rd(od, 0, 0);
			wr(base, `KEY_EXIT);
			`CHK("state", 1'b0, config_state)
			rd(dp, 0, 0);
			wr(op, `OPEN_INDEX_FIRST + k[7:0]);
			rd(od, 1, bank[k]);
			bank[k] = ~d;
			wr(od, bank[k]);
			bad = p[0] ? `OPEN_INDEX_LAST + 8'h01 : `OPEN_INDEX_FIRST - 8'h01;
			wr(op, bad);
			wr(od, d);
			rd(od, 0, 0);
			wr(op, `OPEN_INDEX_FIRST + k[7:0]);
			rd(od, 1, bank[k]);
		end
		wr(base, `KEY_ENTER);
		cfg(`IDX_CONFIG_CONTROL, 8'h01);
		repeat (2) @(negedge sys_clk);
		wr(base, `IDX_DEVICE_NUMBER);
		rd(dp, 1, 8'h00);
		wr(base, `IDX_DEVICE_ID);
		rd(base, 1, `IDX_DEVICE_ID);
		rd(dp, 1, `DEVICE_ID_VALUE);
		cfg(`IDX_OPEN_ACCESS_SELECT, 8'h03);
		wr(base, `KEY_EXIT);
		rd(od, 0, 0);
		wr(base, `KEY_ENTER);
		cfg(`IDX_OPEN_ACCESS_SELECT, sel);
		wr(base, `KEY_EXIT);
		wr(op, `OPEN_INDEX_FIRST + k[7:0]);
		rd(od, 1, 8'h00);
		give_verdict;
	end
endmodule
`default_nettype wire
